// >>> hdl/dcfs_pkg.sv
// dcfs_pkg: constants shared by the DC feeding supply control block
package dcfs_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int DCFS_MCLK_HZ = 125_000_000;
	localparam int DCFS_MS_CYC = DCFS_MCLK_HZ / 1000;
	localparam int DCFS_REARM_MS = 150;
	localparam int DCFS_REARM_CYC = DCFS_REARM_MS * DCFS_MS_CYC;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] DCFS_OFS_REGEN = 8'h00;
	localparam logic [7:0] DCFS_OFS_DUTY = 8'h04;
	localparam logic [7:0] DCFS_OFS_STOP = 8'h08;
	localparam logic [7:0] DCFS_OFS_COAST = 8'h0C;
	localparam logic [7:0] DCFS_OFS_IN_ASG = 8'h10;
	localparam logic [7:0] DCFS_OFS_OUT_ASG = 8'h14;
	localparam logic [7:0] DCFS_OFS_STATUS = 8'h18;

	// ------------------------------------------------------------
	// stop configuration fields
	// ------------------------------------------------------------
	localparam int DCFS_STOP_SEL_LSB = 0;
	localparam int DCFS_STOP_AUTO_BIT = 8;
	localparam int DCFS_STOP_HOLD_BIT = 9;

	// ------------------------------------------------------------
	// status fields
	// ------------------------------------------------------------
	localparam int DCFS_ST_DCF = 0;
	localparam int DCFS_ST_STARTABLE = 1;
	localparam int DCFS_ST_SHUTOFF = 2;
	localparam int DCFS_ST_DECEL = 3;
	localparam int DCFS_ST_CANCEL = 4;
	localparam int DCFS_ST_DC_ONLY = 5;
	localparam int DCFS_ST_BACKUP = 6;
	localparam int DCFS_ST_UV = 7;
	localparam int DCFS_ST_IPF = 8;
	localparam int DCFS_ST_OPT = 9;
	localparam int DCFS_ST_ERR = 10;
	localparam int DCFS_ST_HOLD = 11;
	localparam int DCFS_ST_WIDTH = 12;

	// ------------------------------------------------------------
	// regeneration selection values
	// ------------------------------------------------------------
	localparam logic [7:0] DCFS_RG_0 = 8'h00;
	localparam logic [7:0] DCFS_RG_100 = 8'h64;
	localparam logic [7:0] DCFS_RG_10 = 8'h0A;
	localparam logic [7:0] DCFS_RG_20 = 8'h14;
	localparam logic [7:0] DCFS_RG_120 = 8'h78;
	localparam logic [7:0] DCFS_RG_1 = 8'h01;
	localparam logic [7:0] DCFS_RG_101 = 8'h65;
	localparam logic [7:0] DCFS_RG_11 = 8'h0B;
	localparam logic [7:0] DCFS_RG_21 = 8'h15;
	localparam logic [7:0] DCFS_RG_121 = 8'h79;
	localparam logic [7:0] DCFS_RG_2 = 8'h02;
	localparam logic [7:0] DCFS_RG_RESET = 8'h00;

	// ------------------------------------------------------------
	// terminal function codes and limits
	// ------------------------------------------------------------
	localparam logic [7:0] DCFS_FN_OP_ENABLE = 8'h0A;
	localparam logic [7:0] DCFS_FN_PF_HOLD = 8'h0B;
	localparam logic [7:0] DCFS_FN_PERMIT = 8'h46;
	localparam logic [7:0] DCFS_FN_CANCEL = 8'h47;
	localparam logic [7:0] DCFS_FN_DCF_POS = 8'h55;
	localparam logic [7:0] DCFS_FN_DCF_NEG = 8'hB9;
	localparam logic [7:0] DCFS_FN_NONE = 8'hFF;
	localparam logic [3:0] DCFS_DUTY_MAX = 4'hA;
	localparam logic [3:0] DCFS_DUTY_RESET = 4'h0;

	typedef enum logic [2:0] {RS_READY, RS_TRIPPED, RS_WAIT_ON, RS_DELAY, RS_COAST} dcfs_rs_t;

endpackage

// >>> hdl/dcfs_sync.sv
// dcfs_sync: two-flop synchroniser for contact inputs
`timescale 1ns/10ps
module dcfs_sync #(
	parameter int W = 4
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// >>> hdl/dcfs_timer.sv
// dcfs_timer: loadable down counter with one-cycle done pulse
`timescale 1ns/10ps
module dcfs_timer #(
	parameter int W = 25
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic start,
	input wire logic [W-1:0] load,
	input wire logic tick,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt;
	wire last = (cnt <= {{(W-1){1'b0}}, 1'b1});

	always_ff @(posedge mclk) begin
		if (!rst_b || clr) begin
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			cnt <= load;
			busy <= 1'b1;
			done <= 1'b0;
		end else if (busy && (tick || cnt == '0)) begin
			cnt <= last ? '0 : cnt - 1'b1;
			busy <= !last;
			done <= last;
		end else begin
			done <= 1'b0;
		end
	end
endmodule

// >>> hdl/dcfs_top.sv
// dcfs_top: regeneration selection decode and DC feeding supply sequencing
// What this block does
// - ordinary brake or none: accept 0,10,20,100,120; brake duty ignored
// - larger models also accept 1,11,21,101,121
// - writing 2 resets the drive and shows error; duty ignored
// - function 10 terminal is operation enable; inactive shuts output off while 2 is selected
// - function 11 terminal holds mode on power failure when configured and 2 is selected
// - values 10 and 11 select DC-only supply
// - values 20,21,120,121 select AC with DC backup
// - with 20,21,120,121, DC operation allowed only while permit input (function 70) is on
// - after power-fail shutoff, startable 150 ms after permit off-on, plus coast when auto restart is on
// - with 20,21,120,121, permit off while running: shutoff if stop select 0 or AC lost, else decelerate
// - cancel (function 71) while DC running stops drive, then status off
// - after cancel, operation refused even with permit on
// - with 20,21,120,121, DC feeding status on at AC fail/undervoltage; off on cancel or restore
// - on restore while running status stays on until stop
// - status set by undervoltage stays latched after it clears
// - status survives an inverter reset
// - output terminal code 85 drives status true, 185 inverted
// - values 100,101,120,121 suppress reset at main power on
// - any DC feeding value masks undervoltage and power fail faults
// - AC present with 2, 10 or 11 raises option fault
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module dcfs_top
	import dcfs_pkg::*;
#(
	parameter int N_IN = 4,
	parameter int N_OUT = 2,
	parameter bit LARGE_MODEL = 1'b1,
	parameter int REARM_CYC = DCFS_REARM_CYC,
	parameter int MS_CYC = DCFS_MS_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [N_IN-1:0] term_in,
	input wire logic ac_power_ok,
	input wire logic ac_power_fail,
	input wire logic ac_undervoltage,
	input wire logic motor_running,
	input wire logic main_power_on,
	output logic [N_OUT-1:0] term_out,
	output logic output_shutoff,
	output logic decel_stop_req,
	output logic startable,
	output logic self_reset,
	output logic main_on_reset,
	output logic err_display,
	output logic mode_hold,
	output logic undervoltage_fault,
	output logic instant_power_fail_fault,
	output logic option_fault,
	output logic [3:0] brake_duty_eff
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] regen_function_select;
	logic [3:0] special_brake_duty;
	logic [7:0] power_fail_stop_select;
	logic auto_restart_en;
	logic mode_hold_cfg;
	logic [15:0] restart_coast_time;
	logic [7:0] input_terminal_assign [N_IN];
	logic [7:0] output_terminal_assign [N_OUT];
	logic dc_feeding_status;
	logic uv_mark;
	logic cancel_latched;
	logic permit_q, cancel_q;
	logic [16:0] ms_cnt;
	logic ms_tick;
	dcfs_rs_t rstate, next_rstate;
	wire [DCFS_ST_WIDTH-1:0] status_word;
	wire inv_reset = self_reset || main_on_reset;

	// ------------------------------------------------------------
	// selection decode
	// ------------------------------------------------------------
	wire [7:0] w8 = wdata[7:0];
	wire val_small = (w8 == DCFS_RG_0) || (w8 == DCFS_RG_100) || (w8 == DCFS_RG_10) ||
		(w8 == DCFS_RG_20) || (w8 == DCFS_RG_120) || (w8 == DCFS_RG_2);
	wire val_large = (w8 == DCFS_RG_1) || (w8 == DCFS_RG_101) || (w8 == DCFS_RG_11) ||
		(w8 == DCFS_RG_21) || (w8 == DCFS_RG_121);
	wire regen_ok = val_small || (LARGE_MODEL && val_large);
	wire sel_conv = (regen_function_select == DCFS_RG_2);
	wire dc_only = (regen_function_select == DCFS_RG_10) || (regen_function_select == DCFS_RG_11);
	wire dc_backup = (regen_function_select == DCFS_RG_20) || (regen_function_select == DCFS_RG_21) ||
		(regen_function_select == DCFS_RG_120) || (regen_function_select == DCFS_RG_121);
	wire duty_used = (regen_function_select == DCFS_RG_1) || (regen_function_select == DCFS_RG_101) ||
		(regen_function_select == DCFS_RG_11) || (regen_function_select == DCFS_RG_21) ||
		(regen_function_select == DCFS_RG_121);
	wire no_main_reset = (regen_function_select == DCFS_RG_100) || (regen_function_select == DCFS_RG_101) ||
		(regen_function_select == DCFS_RG_120) || (regen_function_select == DCFS_RG_121);
	wire dc_any = sel_conv || dc_only || dc_backup;

	// ------------------------------------------------------------
	// terminal decode
	// ------------------------------------------------------------
	logic [N_IN-1:0] in_s;
	logic [N_IN-1:0] hit_en, hit_hold, hit_permit, hit_cancel;

	dcfs_sync #(.W(N_IN)) u_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.d(term_in),
		.q(in_s)
	);

	for (genvar i = 0; i < N_IN; i++) begin : g_in
		assign hit_en[i] = in_s[i] && (input_terminal_assign[i] == DCFS_FN_OP_ENABLE);
		assign hit_hold[i] = in_s[i] && (input_terminal_assign[i] == DCFS_FN_PF_HOLD);
		assign hit_permit[i] = in_s[i] && (input_terminal_assign[i] == DCFS_FN_PERMIT);
		assign hit_cancel[i] = in_s[i] && (input_terminal_assign[i] == DCFS_FN_CANCEL);
	end

	wire op_enable = |hit_en;
	wire pf_hold = |hit_hold;
	wire permit = |hit_permit;
	wire cancel = |hit_cancel;
	wire ac_lost = ac_power_fail || ac_undervoltage;
	wire permit_fall_run = permit_q && !permit && motor_running && dc_backup;
	wire cancel_rise_run = cancel && !cancel_q && motor_running && dc_feeding_status;
	wire stop_evt = permit_fall_run || cancel_rise_run;
	wire stop_coast = (power_fail_stop_select == 8'h00);
	wire pf_trip = dc_backup && ac_lost && motor_running && !permit;

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	wire wr_regen = wr && (addr == DCFS_OFS_REGEN);
	wire [31:0] in_asg_word = {input_terminal_assign[3], input_terminal_assign[2],
		input_terminal_assign[1], input_terminal_assign[0]};
	wire [31:0] out_asg_word = {16'h0000, output_terminal_assign[1], output_terminal_assign[0]};
	logic [31:0] rmux;

	always_comb begin
		rmux = 32'h0000_0000;
		if (addr == DCFS_OFS_REGEN) begin
			rmux = {24'h00_0000, regen_function_select};
		end else if (addr == DCFS_OFS_DUTY) begin
			rmux = {28'h000_0000, special_brake_duty};
		end else if (addr == DCFS_OFS_STOP) begin
			rmux = {22'h00_0000, mode_hold_cfg, auto_restart_en, power_fail_stop_select};
		end else if (addr == DCFS_OFS_COAST) begin
			rmux = {16'h0000, restart_coast_time};
		end else if (addr == DCFS_OFS_IN_ASG) begin
			rmux = in_asg_word;
		end else if (addr == DCFS_OFS_OUT_ASG) begin
			rmux = out_asg_word;
		end else if (addr == DCFS_OFS_STATUS) begin
			rmux = {20'h0_0000, status_word};
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			regen_function_select <= DCFS_RG_RESET;
			special_brake_duty <= DCFS_DUTY_RESET;
			power_fail_stop_select <= 8'h00;
			auto_restart_en <= 1'b0;
			mode_hold_cfg <= 1'b0;
			restart_coast_time <= 16'h0000;
			input_terminal_assign <= '{default: DCFS_FN_NONE};
			output_terminal_assign <= '{default: DCFS_FN_NONE};
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= rd ? rmux : 32'h0000_0000;
			// unsupported selection values are dropped, old value kept
			if (wr_regen && regen_ok) begin
				regen_function_select <= w8;
			end
			if (wr && addr == DCFS_OFS_DUTY && wdata[3:0] <= DCFS_DUTY_MAX) begin
				special_brake_duty <= wdata[3:0];
			end
			if (wr && addr == DCFS_OFS_STOP) begin
				power_fail_stop_select <= wdata[DCFS_STOP_SEL_LSB +: 8];
				auto_restart_en <= wdata[DCFS_STOP_AUTO_BIT];
				mode_hold_cfg <= wdata[DCFS_STOP_HOLD_BIT];
			end
			if (wr && addr == DCFS_OFS_COAST) begin
				restart_coast_time <= wdata[15:0];
			end
			if (wr && addr == DCFS_OFS_IN_ASG) begin
				for (int k = 0; k < N_IN; k++) begin
					input_terminal_assign[k] <= wdata[8*k +: 8];
				end
			end
			if (wr && addr == DCFS_OFS_OUT_ASG) begin
				for (int k = 0; k < N_OUT; k++) begin
					output_terminal_assign[k] <= wdata[8*k +: 8];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// DC feeding status, kept across inverter resets
	// ------------------------------------------------------------
	wire dcf_set = dc_backup && ac_lost && !cancel && !cancel_latched;
	wire dcf_clr = !motor_running && ((cancel || cancel_latched) || (!ac_lost && !uv_mark));

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			dc_feeding_status <= 1'b0;
			uv_mark <= 1'b0;
		end else if (dcf_set) begin
			dc_feeding_status <= 1'b1;
			uv_mark <= uv_mark || ac_undervoltage;
		end else if (dcf_clr) begin
			dc_feeding_status <= 1'b0;
			uv_mark <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// restart sequencing
	// ------------------------------------------------------------
	logic rearm_done, coast_done, coast_busy;
	wire enter_delay = (rstate == RS_WAIT_ON) && permit;

	dcfs_timer #(.W(25)) u_rearm (
		.mclk(mclk),
		.rst_b(rst_b),
		.clr(inv_reset),
		.start(enter_delay),
		.load(25'(REARM_CYC)),
		.tick(1'b1),
		.busy(),
		.done(rearm_done)
	);

	dcfs_timer #(.W(16)) u_coast (
		.mclk(mclk),
		.rst_b(rst_b),
		.clr(inv_reset),
		.start(rearm_done && auto_restart_en),
		.load(restart_coast_time),
		.tick(ms_tick),
		.busy(coast_busy),
		.done(coast_done)
	);

	always_comb begin
		next_rstate = rstate;
		case (rstate)
			RS_READY: begin
				if (pf_trip || (stop_evt && stop_coast)) begin
					next_rstate = RS_TRIPPED;
				end
			end
			RS_TRIPPED: begin
				if (!permit) begin
					next_rstate = RS_WAIT_ON;
				end
			end
			RS_WAIT_ON: begin
				if (permit) begin
					next_rstate = RS_DELAY;
				end
			end
			RS_DELAY: begin
				if (rearm_done) begin
					next_rstate = auto_restart_en ? RS_COAST : RS_READY;
				end
			end
			RS_COAST: begin
				if (coast_done) begin
					next_rstate = RS_READY;
				end
			end
			default: next_rstate = RS_READY;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b || inv_reset) begin
			rstate <= RS_READY;
			cancel_latched <= 1'b0;
			decel_stop_req <= 1'b0;
			undervoltage_fault <= 1'b0;
			instant_power_fail_fault <= 1'b0;
			option_fault <= 1'b0;
			permit_q <= 1'b0;
			cancel_q <= 1'b0;
			ms_cnt <= 17'h0_0000;
			ms_tick <= 1'b0;
		end else begin
			rstate <= next_rstate;
			permit_q <= permit;
			cancel_q <= cancel;
			ms_tick <= (ms_cnt == 17'(MS_CYC - 1));
			ms_cnt <= (ms_cnt == 17'(MS_CYC - 1) || !coast_busy) ? 17'h0_0000 : ms_cnt + 1'b1;
			// cleared by an inverter reset, or once the contact is off, mains is back and status is off
			if (cancel && (dc_backup || dc_feeding_status)) begin
				cancel_latched <= 1'b1;
			end else if (!cancel && ac_power_ok && !dc_feeding_status) begin
				cancel_latched <= 1'b0;
			end
			if (stop_evt && !stop_coast) begin
				decel_stop_req <= 1'b1;
			end else if (!motor_running) begin
				decel_stop_req <= 1'b0;
			end
			undervoltage_fault <= !dc_any && (undervoltage_fault || ac_undervoltage);
			instant_power_fail_fault <= !dc_any && (instant_power_fail_fault || ac_power_fail);
			option_fault <= option_fault || (ac_power_ok && (sel_conv || dc_only));
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	wire next_shutoff = (sel_conv && !op_enable) || (rstate != RS_READY);
	wire next_startable = (rstate == RS_READY) && !cancel_latched && !cancel && !next_shutoff &&
		!(dc_feeding_status && !permit);
	logic [N_OUT-1:0] next_term_out;

	for (genvar j = 0; j < N_OUT; j++) begin : g_out
		assign next_term_out[j] = (output_terminal_assign[j] == DCFS_FN_DCF_POS) ? dc_feeding_status :
			(output_terminal_assign[j] == DCFS_FN_DCF_NEG) ? !dc_feeding_status : 1'b0;
	end

	assign status_word = {mode_hold, err_display, option_fault, instant_power_fail_fault,
		undervoltage_fault, dc_backup, dc_only, cancel_latched, decel_stop_req, output_shutoff,
		startable, dc_feeding_status};

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			term_out <= '0;
			output_shutoff <= 1'b0;
			startable <= 1'b0;
			self_reset <= 1'b0;
			main_on_reset <= 1'b0;
			err_display <= 1'b0;
			mode_hold <= 1'b0;
			brake_duty_eff <= 4'h0;
		end else begin
			term_out <= next_term_out;
			output_shutoff <= next_shutoff;
			startable <= next_startable;
			self_reset <= wr_regen && (w8 == DCFS_RG_2);
			err_display <= wr_regen ? (w8 == DCFS_RG_2) : err_display;
			main_on_reset <= main_power_on && !no_main_reset && !dc_only && !sel_conv;
			mode_hold <= sel_conv && mode_hold_cfg && pf_hold;
			brake_duty_eff <= (LARGE_MODEL && duty_used) ? special_brake_duty : 4'h0;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_rearm;
		(rstate == RS_WAIT_ON) && permit;
	endsequence

	sequence s_conv_write;
		wr_regen && (w8 == DCFS_RG_2);
	endsequence

	AST_TERM_POL: assert property (@(posedge mclk) disable iff (!rst_b)
		(output_terminal_assign[1] == DCFS_FN_DCF_NEG) && $stable(output_terminal_assign[1])
		|=> term_out[1] == !$past(dc_feeding_status)) else $error("terminal polarity wrong");
	AST_DCF_SET: assert property (@(posedge mclk) disable iff (!rst_b)
		dcf_set |=> dc_feeding_status) else $error("dc feeding status not set");
	AST_DCF_RUN: assert property (@(posedge mclk) disable iff (!rst_b)
		dc_feeding_status && motor_running |=> dc_feeding_status) else $error("status dropped while running");
	AST_DCF_UV: assert property (@(posedge mclk) disable iff (!rst_b)
		dc_feeding_status && uv_mark && !cancel && !cancel_latched |=> dc_feeding_status)
		else $error("undervoltage latch lost");
	AST_CANCEL: assert property (@(posedge mclk) disable iff (!rst_b)
		cancel_latched |=> !startable) else $error("startable after cancel");
	AST_REARM: assert property (@(posedge mclk) disable iff (!rst_b || inv_reset)
		s_rearm |=> (!startable && rstate == RS_DELAY) [*8]) else $error("restart too early");
	AST_OPEN: assert property (@(posedge mclk) disable iff (!rst_b)
		sel_conv && !op_enable |=> output_shutoff) else $error("no shutoff without enable");
	AST_MASK: assert property (@(posedge mclk) disable iff (!rst_b)
		dc_any && !inv_reset |=> !undervoltage_fault && !instant_power_fail_fault)
		else $error("fault raised during dc feeding");
	AST_OPT: assert property (@(posedge mclk) disable iff (!rst_b)
		ac_power_ok && dc_only && !inv_reset |=> option_fault) else $error("option fault missing");
	AST_SELF_RST: assert property (@(posedge mclk) disable iff (!rst_b)
		s_conv_write |=> self_reset && err_display ##1 !self_reset) else $error("self reset missing");
	AST_DECEL: assert property (@(posedge mclk) disable iff (!rst_b || inv_reset)
		stop_evt && !stop_coast |=> decel_stop_req) else $error("decel request missing");
endmodule

// >>> verif/dcfs_contact_model.sv
// dcfs_contact_model: external converter or DC supply driving the contact inputs
`timescale 1ns/10ps
module dcfs_contact_model (
	input wire logic mclk,
	input wire logic slow,
	input wire logic permit,
	input wire logic cancel,
	input wire logic enable,
	input wire logic hold,
	output logic [3:0] term_in
);
	logic [15:0] dly;
	wire [3:0] cmd = {hold, enable, cancel, permit};
	// a slow unit answers four cycles late, as relay contacts do
	always_ff @(posedge mclk) begin
		dly <= {dly[11:0], cmd};
	end
	assign term_in = slow ? dly[15:12] : cmd;
endmodule

// >>> verif/dcfs_top_test.sv
// dcfs_top_test: self-checking bench for the DC feeding supply control block
`timescale 1ns/10ps
module dcfs_top_test import dcfs_pkg::*;;
	logic mclk, rst_b, wr, rd, ac_ok, ac_fail, ac_uv, run, mpo;
	logic permit, cancel, enable, hold, slow;
	logic shutoff, decel, startable, sres, mor, errd, mhold, uvf, ipf, optf;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, v;
	logic [3:0] term_in, duty;
	logic [1:0] term_out;
	int fails = 0;
	int comparisons = 0;
	int tick = 0;
	int waited = 0;
	logic [7:0] ok_v [10] = '{8'h00, 8'h0A, 8'h14, 8'h64, 8'h78, 8'h01, 8'h0B, 8'h15, 8'h65, 8'h79};

	dcfs_contact_model model (.mclk(mclk), .slow(slow), .permit(permit), .cancel(cancel), .enable(enable),
		.hold(hold), .term_in(term_in));
	dcfs_top #(.REARM_CYC(40), .MS_CYC(4)) dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .term_in(term_in), .ac_power_ok(ac_ok), .ac_power_fail(ac_fail),
		.ac_undervoltage(ac_uv), .motor_running(run), .main_power_on(mpo), .term_out(term_out),
		.output_shutoff(shutoff), .decel_stop_req(decel), .startable(startable), .self_reset(sres),
		.main_on_reset(mor), .err_display(errd), .mode_hold(mhold), .undervoltage_fault(uvf),
		.instant_power_fail_fault(ipf), .option_fault(optf), .brake_duty_eff(duty));

	// ------------------------------------------------------------
	// clock, timeout and shared tasks
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		tick <= tick + 1;
		if (tick == 20000) begin
			fails++;
			finish_test;
		end
	end
	task finish_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rdr(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task mpo_pulse(input logic exp);
		@(posedge mclk);
		mpo <= 1'b1;
		@(posedge mclk);
		mpo <= 1'b0;
		#1 chk(32'(mor), 32'(exp));
	endtask
	// counts edges until the drive reports startable, with a ceiling of 100
	task wait_start;
		waited = 0;
		while (startable !== 1'b1 && waited < 100) begin
			@(posedge mclk);
			waited++;
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_b, wr, rd, ac_ok, ac_fail, ac_uv, run, mpo, permit, cancel, enable, hold, slow} = '0;
		addr = 8'h00;
		wdata = 32'h0;
		cyc(6);
		rst_b <= 1'b1;
		rdr(DCFS_OFS_IN_ASG);
		chk(v, 32'hFFFFFFFF);
		rdr(8'h20);
		chk(v, 32'h0);
		wrr(DCFS_OFS_IN_ASG, 32'h0B0A4746);
		wrr(DCFS_OFS_OUT_ASG, 32'h0000B955);
		foreach (ok_v[i]) begin
			wrr(DCFS_OFS_REGEN, 32'(ok_v[i]));
			rdr(DCFS_OFS_REGEN);
			chk(v, 32'(ok_v[i]));
		end
		wrr(DCFS_OFS_REGEN, 32'h03);
		rdr(DCFS_OFS_REGEN);
		chk(v, 32'h79);
		wrr(DCFS_OFS_DUTY, 32'h0A);
		cyc(2);
		chk(32'(duty), 32'hA);
		wrr(DCFS_OFS_DUTY, 32'h0B);
		rdr(DCFS_OFS_DUTY);
		chk(v, 32'hA);
		wrr(DCFS_OFS_REGEN, 32'h0A);
		cyc(2);
		chk(32'(duty), 32'h0);
		wrr(DCFS_OFS_STOP, 32'h200);
		wrr(DCFS_OFS_REGEN, 32'h02);
		#1 chk(32'(sres), 32'h1);
		chk(32'(errd), 32'h1);
		hold <= 1'b1;
		cyc(6);
		chk(32'(shutoff), 32'h1);
		chk(32'(mhold), 32'h1);
		enable <= 1'b1;
		cyc(6);
		chk(32'(shutoff), 32'h0);
		ac_ok <= 1'b1;
		cyc(4);
		chk(32'(optf), 32'h1);
		ac_ok <= 1'b0;
		wrr(DCFS_OFS_REGEN, 32'h00);
		mpo_pulse(1'b1);
		// the power-on reset clears the sticky fault one edge after the pulse
		cyc(2);
		chk(32'(optf), 32'h0);
		wrr(DCFS_OFS_REGEN, 32'h0B);
		ac_ok <= 1'b1;
		cyc(4);
		chk(32'(optf), 32'h1);
		ac_ok <= 1'b0;
		wrr(DCFS_OFS_REGEN, 32'h14);
		mpo_pulse(1'b1);
		// backup mode: permit must clear the synchroniser before AC is lost, or the drive trips
		wrr(DCFS_OFS_STOP, 32'h1);
		run <= 1'b1;
		permit <= 1'b1;
		cyc(4);
		ac_fail <= 1'b1;
		cyc(6);
		chk(32'(term_out), 32'h1);
		chk(32'(shutoff), 32'h0);
		chk(32'({uvf, ipf}), 32'h0);
		cancel <= 1'b1;
		cyc(6);
		chk(32'(decel), 32'h1);
		chk(32'(term_out), 32'h1);
		run <= 1'b0;
		cyc(4);
		chk(32'(term_out), 32'h2);
		rdr(DCFS_OFS_STATUS);
		chk(v & 32'h12, 32'h10);
		cancel <= 1'b0;
		ac_ok <= 1'b1;
		ac_fail <= 1'b0;
		cyc(6);
		// power-failure trip with a slow partner, then the rearm delay
		wrr(DCFS_OFS_STOP, 32'h0);
		slow <= 1'b1;
		ac_ok <= 1'b0;
		ac_fail <= 1'b1;
		run <= 1'b1;
		cyc(10);
		permit <= 1'b0;
		cyc(10);
		chk(32'(shutoff), 32'h1);
		run <= 1'b0;
		permit <= 1'b1;
		cyc(20);
		chk(32'(startable), 32'h0);
		wait_start;
		chk(32'(startable), 32'h1);
		ac_fail <= 1'b0;
		ac_ok <= 1'b1;
		cyc(8);
		chk(32'(term_out), 32'h2);
		ac_uv <= 1'b1;
		cyc(8);
		ac_uv <= 1'b0;
		cyc(8);
		chk(32'(term_out), 32'h1);
		chk(32'(uvf), 32'h0);
		mpo_pulse(1'b1);
		cyc(3);
		chk(32'(term_out), 32'h1);
		wrr(DCFS_OFS_REGEN, 32'h78);
		mpo_pulse(1'b0);
		// automatic restart adds the coasting wait (2 ms of 4 cycles) after the 40-cycle rearm
		wrr(DCFS_OFS_STOP, 32'h100);
		wrr(DCFS_OFS_COAST, 32'h2);
		ac_ok <= 1'b0;
		ac_fail <= 1'b1;
		run <= 1'b1;
		cyc(4);
		permit <= 1'b0;
		cyc(12);
		chk(32'(shutoff), 32'h1);
		run <= 1'b0;
		permit <= 1'b1;
		wait_start;
		chk(32'(waited >= 56 && waited <= 64), 32'h1);
		finish_test;
	end
endmodule
